// ===== accel_config_calib_regs.sv
// Configuration and calibration register slice of a three-axis accelerometer
// How it works
// - Identity register is fixed and ignores writes
// - Writing one to bit 6 forces reset
// - Forced reset reloads calibration, clears others
// - Forced-reset bit clears itself after reset
// - Range field bits 6:4 selects full scale
// - Axis biases are sign-extended two's complement
// - Bit 3 switches smoothing filter in
// - Bits 2:0 choose the filter cutoff divisor
// - Per-axis signed bias added after filter
// - High byte bit 7 is scale bit 8
// - Calibration loaded from OTP, software may overwrite
module accel_config_calib_regs #(
    parameter logic [7:0] CHIP_IDENTITY_VALUE = 8'h5a  // Arbitrary identification value
) (
    input  wire logic        CLK,
    input  wire logic        SYS_RST,
    input  wire logic        REG_WR,
    input  wire logic        REG_RD,
    input  wire logic [7:0]  REG_ADDR,
    input  wire logic [7:0]  REG_WDATA,
    output logic      [7:0]  REG_RDATA,
    output logic             REG_RVALID,
    input  wire logic [47:0] OTP_CAL_DATA,
    input  wire logic        STANDBY_MODE,
    output logic             FORCED_RESET_PULSE,
    output logic      [2:0]  FULL_SCALE_SEL,
    output logic             SMOOTHING_ENABLE,
    output logic      [2:0]  CUTOFF_SELECT,
    output logic             CUTOFF_RESERVED,
    output logic      [14:0] X_AXIS_BIAS,
    output logic      [14:0] Y_AXIS_BIAS,
    output logic      [14:0] Z_AXIS_BIAS,
    output logic             X_AXIS_SCALE_MSB,
    output logic             Y_AXIS_SCALE_MSB,
    output logic             Z_AXIS_SCALE_MSB,
    input  wire logic [15:0] X_FILTERED,
    input  wire logic [15:0] Y_FILTERED,
    input  wire logic [15:0] Z_FILTERED,
    output logic      [15:0] X_RESULT,
    output logic      [15:0] Y_RESULT,
    output logic      [15:0] Z_RESULT
);
    // Load sequencer states: power-up load, normal running, forced reload
    typedef enum logic [1:0] {ST_LOAD, ST_RUN, ST_RELOAD} seq_e;

    // Sequencer state and load cycle counter
    seq_e        state_ff, nxt_state;
    logic [1:0]  cnt_ff, nxt_cnt;

    // Host-visible control and calibration bytes
    logic [7:0]  range_ff, nxt_range;
    logic [7:0]  rst_ctl_ff, nxt_rst_ctl;
    logic [7:0]  cal_ff [6], nxt_cal [6];   // X low, X high, Y low, Y high, Z low, Z high
    logic [7:0]  rdata_ff, nxt_rdata;
    logic        rvalid_ff, nxt_rvalid;
    logic        pulse_ff, nxt_pulse;
    logic        rsv_ff, nxt_rsv;

    // Per-axis datapath values
    logic [15:0] res_ff [3], nxt_res [3];
    logic [15:0] filt [3];
    logic [14:0] bias [3];

    // Filter outputs gathered per axis for the generate loop
    assign filt[0] = X_FILTERED;
    assign filt[1] = Y_FILTERED;
    assign filt[2] = Z_FILTERED;

    // Register write, reload sequencing and readback
    always_comb begin
        nxt_state   = state_ff;
        nxt_cnt     = cnt_ff;
        nxt_range   = range_ff;
        nxt_rst_ctl = rst_ctl_ff;
        nxt_cal     = cal_ff;
        nxt_rdata   = rdata_ff;
        nxt_rvalid  = REG_RD;
        nxt_pulse   = 1'b0;

        // Load from stored calibration, or decode host writes
        case (state_ff)
            ST_LOAD, ST_RELOAD: begin
                // Stored calibration is copied every load cycle
                for (int i = 0; i < 6; i++) begin
                    nxt_cal[i] = OTP_CAL_DATA[i*8 +: 8];
                end
                nxt_range = accel_cfg_pkg::RANGE_FILTER_RST;
                nxt_cnt   = cnt_ff + 2'h1;
                // Last load cycle: run, and clear the forced-reset request
                if (cnt_ff == accel_cfg_pkg::RELOAD_LAST) begin
                    nxt_state   = ST_RUN;
                    nxt_cnt     = 2'h0;
                    nxt_rst_ctl = accel_cfg_pkg::SOFT_RESET_RST;
                end
            end
            ST_RUN: begin
                // Host writes, taken only while running
                if (REG_WR) begin
                    case (REG_ADDR)
                        accel_cfg_pkg::ADDR_SOFT_RESET: begin
                            nxt_rst_ctl = REG_WDATA;
                            if (REG_WDATA[accel_cfg_pkg::FORCE_RESET_BIT]) begin
                                nxt_state = ST_RELOAD; // Enter reload sequence
                                nxt_pulse = 1'b1;
                            end
                        end
                        accel_cfg_pkg::ADDR_RANGE_FILTER: nxt_range = REG_WDATA;
                        accel_cfg_pkg::ADDR_X_OFF_LOW:  nxt_cal[0] = REG_WDATA;
                        accel_cfg_pkg::ADDR_X_OFF_HIGH: nxt_cal[1] = REG_WDATA;
                        accel_cfg_pkg::ADDR_Y_OFF_LOW:  nxt_cal[2] = REG_WDATA;
                        accel_cfg_pkg::ADDR_Y_OFF_HIGH: nxt_cal[3] = REG_WDATA;
                        accel_cfg_pkg::ADDR_Z_OFF_LOW:  nxt_cal[4] = REG_WDATA;
                        accel_cfg_pkg::ADDR_Z_OFF_HIGH: nxt_cal[5] = REG_WDATA;
                        default: ; // Identity and unmapped writes ignored
                    endcase
                end
            end
            default: nxt_state = ST_LOAD;
        endcase

        // Readback of the addressed register, taken before this edge's write
        if (REG_RD) begin
            case (REG_ADDR)
                accel_cfg_pkg::ADDR_CHIP_IDENTITY: nxt_rdata = CHIP_IDENTITY_VALUE;
                accel_cfg_pkg::ADDR_SOFT_RESET:    nxt_rdata = rst_ctl_ff;
                accel_cfg_pkg::ADDR_RANGE_FILTER:  nxt_rdata = range_ff;
                accel_cfg_pkg::ADDR_X_OFF_LOW:     nxt_rdata = cal_ff[0];
                accel_cfg_pkg::ADDR_X_OFF_HIGH:    nxt_rdata = cal_ff[1];
                accel_cfg_pkg::ADDR_Y_OFF_LOW:     nxt_rdata = cal_ff[2];
                accel_cfg_pkg::ADDR_Y_OFF_HIGH:    nxt_rdata = cal_ff[3];
                accel_cfg_pkg::ADDR_Z_OFF_LOW:     nxt_rdata = cal_ff[4];
                accel_cfg_pkg::ADDR_Z_OFF_HIGH:    nxt_rdata = cal_ff[5];
                default:                           nxt_rdata = accel_cfg_pkg::BYTE_ZERO;
            endcase
        end

        // Flag cutoff codes that select no bandwidth setting
        case (nxt_range[2:0])
            accel_cfg_pkg::CUTOFF_DIV_4P255,
            accel_cfg_pkg::CUTOFF_DIV_6,
            accel_cfg_pkg::CUTOFF_DIV_12,
            accel_cfg_pkg::CUTOFF_DIV_16: nxt_rsv = 1'b0;
            default:                      nxt_rsv = 1'b1;
        endcase
    end

    // Control and calibration registers
    always_ff @(posedge CLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            state_ff   <= ST_LOAD;
            cnt_ff     <= 2'h0;
            range_ff   <= accel_cfg_pkg::RANGE_FILTER_RST;
            rst_ctl_ff <= accel_cfg_pkg::SOFT_RESET_RST;
            // Calibration bytes read zero until the first load
            for (int i = 0; i < 6; i++) begin
                cal_ff[i] <= accel_cfg_pkg::BYTE_ZERO;
            end
            rdata_ff   <= accel_cfg_pkg::BYTE_ZERO;
            rvalid_ff  <= 1'b0;
            pulse_ff   <= 1'b0;
            rsv_ff     <= 1'b1; // Cutoff code 000 is reserved
        end else begin
            state_ff   <= nxt_state;
            cnt_ff     <= nxt_cnt;
            range_ff   <= nxt_range;
            rst_ctl_ff <= nxt_rst_ctl;
            cal_ff     <= nxt_cal;
            rdata_ff   <= nxt_rdata;
            rvalid_ff  <= nxt_rvalid;
            pulse_ff   <= nxt_pulse;
            rsv_ff     <= nxt_rsv;
        end
    end

    // Per-axis bias assembly and bias addition
    for (genvar a = 0; a < 3; a++) begin : g_axis
        // High byte bit 7 carries the scale MSB, so it is left out
        assign bias[a] = {cal_ff[2*a+1][6:0], cal_ff[2*a]};
        // Sign-extended bias is added so negative offsets wrap correctly
        always_comb begin
            nxt_res[a] = filt[a] + {bias[a][14], bias[a]};
        end
        // Result register, one cycle after the filter sample
        always_ff @(posedge CLK or posedge SYS_RST) begin
            if (SYS_RST) begin
                res_ff[a] <= 16'h0000;
            end else begin
                res_ff[a] <= nxt_res[a];
            end
        end
    end

    // Output assignments
    assign REG_RDATA          = rdata_ff;
    assign REG_RVALID         = rvalid_ff;
    assign FORCED_RESET_PULSE = pulse_ff;

    // Range and filter fields
    assign FULL_SCALE_SEL     = range_ff[6:4];
    assign SMOOTHING_ENABLE   = range_ff[accel_cfg_pkg::SMOOTH_EN_BIT];
    assign CUTOFF_SELECT      = range_ff[2:0];
    assign CUTOFF_RESERVED    = rsv_ff;

    // Calibration fields
    assign X_AXIS_BIAS        = bias[0];
    assign Y_AXIS_BIAS        = bias[1];
    assign Z_AXIS_BIAS        = bias[2];
    assign X_AXIS_SCALE_MSB   = cal_ff[1][accel_cfg_pkg::SCALE_MSB_BIT];
    assign Y_AXIS_SCALE_MSB   = cal_ff[3][accel_cfg_pkg::SCALE_MSB_BIT];
    assign Z_AXIS_SCALE_MSB   = cal_ff[5][accel_cfg_pkg::SCALE_MSB_BIT];

    // Biased axis results
    assign X_RESULT           = res_ff[0];
    assign Y_RESULT           = res_ff[1];
    assign Z_RESULT           = res_ff[2];
endmodule : accel_config_calib_regs

// ===== accel_cfg_pkg.sv
// Package: register offsets, field positions, reset values and timing for the config slice
package accel_cfg_pkg;
    localparam logic [7:0] ADDR_CHIP_IDENTITY = 8'h18;
    localparam logic [7:0] ADDR_SOFT_RESET    = 8'h1c;
    localparam logic [7:0] ADDR_RANGE_FILTER  = 8'h20;
    localparam logic [7:0] ADDR_X_OFF_LOW     = 8'h21;
    localparam logic [7:0] ADDR_X_OFF_HIGH    = 8'h22;
    localparam logic [7:0] ADDR_Y_OFF_LOW     = 8'h23;
    localparam logic [7:0] ADDR_Y_OFF_HIGH    = 8'h24;
    localparam logic [7:0] ADDR_Z_OFF_LOW     = 8'h25;
    localparam logic [7:0] ADDR_Z_OFF_HIGH    = 8'h26;
    localparam int         FORCE_RESET_BIT    = 6;
    localparam int         SMOOTH_EN_BIT      = 3;
    localparam int         SCALE_MSB_BIT      = 7;
    localparam logic [7:0] RANGE_FILTER_RST   = 8'h00;
    localparam logic [7:0] SOFT_RESET_RST     = 8'h00;
    localparam logic [7:0] BYTE_ZERO          = 8'h00;
    localparam logic [2:0] RANGE_2G           = 3'h0;
    localparam logic [2:0] RANGE_4G           = 3'h1;
    localparam logic [2:0] RANGE_8G           = 3'h2;
    localparam logic [2:0] RANGE_16G          = 3'h3;
    localparam logic [2:0] RANGE_12G          = 3'h4;
    localparam logic [2:0] CUTOFF_DIV_4P255   = 3'h1;
    localparam logic [2:0] CUTOFF_DIV_6       = 3'h2;
    localparam logic [2:0] CUTOFF_DIV_12      = 3'h3;
    localparam logic [2:0] CUTOFF_DIV_16      = 3'h5;
    localparam int         RELOAD_CYCLES      = 2;
    localparam logic [1:0] RELOAD_LAST        = 2'(RELOAD_CYCLES - 1);
endpackage : accel_cfg_pkg

// ===== accel_cfg_chk_sva.sv
// Checker: port-level properties of the configuration register slice
module accel_cfg_chk #(
    parameter logic [7:0] CHIP_IDENTITY_VALUE = 8'h5a  // Arbitrary identification value
) (
    input wire logic        CLK,
    input wire logic        SYS_RST,
    input wire logic        REG_WR,
    input wire logic        REG_RD,
    input wire logic [7:0]  REG_ADDR,
    input wire logic [7:0]  REG_WDATA,
    input wire logic [7:0]  REG_RDATA,
    input wire logic [47:0] OTP_CAL_DATA,
    input wire logic        FORCED_RESET_PULSE,
    input wire logic [2:0]  FULL_SCALE_SEL,
    input wire logic        SMOOTHING_ENABLE,
    input wire logic [2:0]  CUTOFF_SELECT,
    input wire logic        CUTOFF_RESERVED,
    input wire logic [14:0] X_AXIS_BIAS,
    input wire logic        X_AXIS_SCALE_MSB,
    input wire logic [15:0] X_FILTERED,
    input wire logic [15:0] X_RESULT
);
    default clocking @(posedge CLK); endclocking
    default disable iff (SYS_RST);
    // Register bus, forced reload and bias datapath relations
    property p_id; REG_RD && REG_ADDR == 8'h18 |=> REG_RDATA == CHIP_IDENTITY_VALUE; endproperty
    a_id: assert property (p_id) else $error("identity read wrong");
    property p_force; REG_WR && REG_ADDR == 8'h1c && REG_WDATA[6] |=> FORCED_RESET_PULSE; endproperty
    a_force: assert property (p_force) else $error("no forced reset");
    property p_selfclr; FORCED_RESET_PULSE ##2 REG_RD && REG_ADDR == 8'h1c |=> !REG_RDATA[6]; endproperty
    a_selfclr: assert property (p_selfclr) else $error("reset bit stuck");
    property p_reload; FORCED_RESET_PULSE |=> !FULL_SCALE_SEL && X_AXIS_BIAS == OTP_CAL_DATA[14:0]
        && X_AXIS_SCALE_MSB == OTP_CAL_DATA[15]; endproperty
    a_reload: assert property (p_reload) else $error("reload wrong");
    property p_range; REG_WR && REG_ADDR == 8'h20 |=>
        {FULL_SCALE_SEL, SMOOTHING_ENABLE, CUTOFF_SELECT} == $past(REG_WDATA[6:0]); endproperty
    a_range: assert property (p_range) else $error("range fields wrong");
    property p_rsv; CUTOFF_RESERVED == !(CUTOFF_SELECT inside {3'h1, 3'h2, 3'h3, 3'h5}); endproperty
    a_rsv: assert property (p_rsv) else $error("cutoff reserved flag wrong");
    property p_high; REG_WR && REG_ADDR == 8'h22 |=>
        {X_AXIS_SCALE_MSB, X_AXIS_BIAS[14:8]} == $past(REG_WDATA); endproperty
    a_high: assert property (p_high) else $error("high byte split wrong");
    property p_sum; !$past(SYS_RST) |->
        X_RESULT == $past(X_FILTERED) + {$past(X_AXIS_BIAS[14]), $past(X_AXIS_BIAS)}; endproperty
    a_sum: assert property (p_sum) else $error("biased result wrong");
endmodule : accel_cfg_chk

bind accel_config_calib_regs accel_cfg_chk #(.CHIP_IDENTITY_VALUE(CHIP_IDENTITY_VALUE)) i_chk (.*);

// ===== accel_config_calib_regs_tb_top.sv
// Testbench: register reads and writes, forced reload and bias datapath
module accel_config_calib_regs_tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    localparam logic [7:0] ID = 8'h3c;  // Arbitrary identification value
    logic CLK = 1'b0, SYS_RST, REG_WR, REG_RD, REG_RVALID, STANDBY_MODE, FORCED_RESET_PULSE;
    logic SMOOTHING_ENABLE, CUTOFF_RESERVED, X_AXIS_SCALE_MSB, Y_AXIS_SCALE_MSB, Z_AXIS_SCALE_MSB;
    logic [7:0]  REG_ADDR, REG_WDATA, REG_RDATA, exp_q[$];
    logic [2:0]  FULL_SCALE_SEL, CUTOFF_SELECT;
    logic [14:0] X_AXIS_BIAS, Y_AXIS_BIAS, Z_AXIS_BIAS, bias;
    logic [15:0] X_FILTERED, Y_FILTERED, Z_FILTERED, X_RESULT, Y_RESULT, Z_RESULT;
    logic [47:0] OTP_CAL_DATA;
    int seed = 32'hcdcf;
    int mismatches = 0;
    int checks_done = 0;
    accel_config_calib_regs #(.CHIP_IDENTITY_VALUE(ID)) i_dut (.*);
    // Clock
    always #25 CLK = ~CLK;
    task check(input string name, input logic [15:0] seen, input logic [15:0] exp);
        checks_done++;
        if (seen !== exp) begin
            mismatches++;
            $display("BAD %s exp %h seen %h", name, exp, seen);
        end
    endtask : check
    task test_done;
        if (mismatches == 0 && checks_done > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask : test_done
    // One bus cycle: write when w, else read and note the expected data
    task acc(input logic w, input logic [7:0] a, input logic [7:0] d);
        @(negedge CLK);
        {REG_WR, REG_RD, REG_ADDR, REG_WDATA} = {w, !w, a, d};
        if (!w)
            exp_q.push_back(d);
        @(negedge CLK);
        {REG_WR, REG_RD} = 2'b00;
    endtask : acc
    // Read data monitor: oldest note against each answer
    always @(negedge CLK) begin
        if (REG_RVALID === 1'b1)
            check("rdata", {8'h00, REG_RDATA}, {8'h00, exp_q.pop_front()});
    end
    // Main sequence
    initial begin
        {SYS_RST, REG_WR, REG_RD, STANDBY_MODE, REG_ADDR, REG_WDATA} = 20'h80000;
        OTP_CAL_DATA = 48'({$random(seed), $random(seed)});
        {X_FILTERED, Y_FILTERED, Z_FILTERED} = 48'({$random(seed), $random(seed)});
        repeat (12) @(negedge CLK);
        SYS_RST = 1'b0;
        repeat (3) @(negedge CLK);
        check("ybias", {Y_AXIS_SCALE_MSB, Y_AXIS_BIAS}, OTP_CAL_DATA[31:16]);
        check("zbias", {Z_AXIS_SCALE_MSB, Z_AXIS_BIAS}, OTP_CAL_DATA[47:32]);
        check("yres", Y_RESULT, Y_FILTERED + {OTP_CAL_DATA[30], OTP_CAL_DATA[30:16]});
        check("zres", Z_RESULT, Z_FILTERED + {OTP_CAL_DATA[46], OTP_CAL_DATA[46:32]});
        acc(1'b0, 8'h18, ID);
        acc(1'b1, 8'h18, 8'hff);
        acc(1'b0, 8'h18, ID);
        acc(1'b0, 8'h30, 8'h00);
        for (int i = 0; i < 6; i++) begin
            acc(1'b0, 8'h21 + 8'(i), OTP_CAL_DATA[8*i +: 8]);
        end
        for (int i = 0; i < 8; i++) begin
            acc(1'b1, 8'h20, {1'b0, 3'(i), i[0], 3'(7 - i)});
            check("range", {13'h0, FULL_SCALE_SEL}, 16'(i));
            check("filter", {12'h0, SMOOTHING_ENABLE, CUTOFF_SELECT}, {12'h0, i[0], 3'(7 - i)});
            check("rsv", {15'h0, CUTOFF_RESERVED}, {15'h0, !((7 - i) inside {1, 2, 3, 5})});
        end
        bias = 15'($random(seed));
        acc(1'b1, 8'h21, bias[7:0]);
        acc(1'b1, 8'h22, {1'b1, bias[14:8]});
        check("bias", {X_AXIS_SCALE_MSB, X_AXIS_BIAS}, {1'b1, bias});
        X_FILTERED = 16'($random(seed));
        @(negedge CLK);
        check("result", X_RESULT, X_FILTERED + {bias[14], bias});
        STANDBY_MODE = 1'b1;
        acc(1'b1, 8'h1c, 8'h40);
        check("pulse", {15'h0, FORCED_RESET_PULSE}, 16'h0001);
        @(negedge CLK);
        check("pulse end", {15'h0, FORCED_RESET_PULSE}, 16'h0000);
        check("reload", {X_AXIS_SCALE_MSB, X_AXIS_BIAS}, OTP_CAL_DATA[15:0]);
        check("range clr", {13'h0, FULL_SCALE_SEL}, 16'h0000);
        acc(1'b0, 8'h1c, 8'h00);
        acc(1'b0, 8'h20, 8'h00);
        acc(1'b0, 8'h22, OTP_CAL_DATA[15:8]);
        repeat (3) @(negedge CLK);
        test_done;
    end
    // Watchdog
    initial begin
        #(50 * 2000);
        mismatches++;
        test_done;
    end
endmodule : accel_config_calib_regs_tb_top
